// file: common/synth_params.svh
// Overview of operation
// - Each serial clock rising edge shifts one data bit into the 24-bit register.
// - Words arrive MSB first; the first bit ends at bit 23.
// - Load strobe rising edge copies the word into exactly one latch.
// - Select 00 control, 01 reference, 10 feedback, 11 factory test.
// - Precision clear: lock after three consecutive cycles under 15 ns error.
// - Precision set: lock after five consecutive cycles under 15 ns error.
// - Lock holds until power-down or until any later cycle shows error above 25 ns.
// - Control bits 7..5 choose the signal driving the test output pin.
// - Band selection starts at power-up and on each feedback latch write.
// - Band selection lasts five band clock cycles with tuning tied to reference.
// - Band clock is reference output prescaled by 1, 2, 4 or 8.
// - Control bits 3..2 select one of four core current steps.
// - Control bits 13..12 select one of four output drive levels.
// - With mute bit 11 set, output supply stays off until lock.
// - Control latch fields occupy bits 23 down to 2 as listed.
// - Feedback latch holds route, half-rate, gain, B count, reserved, A count.
// - Detector compares reference output with feedback output, ratio B*P+A.
// - Reference latch two-bit field sets antibacklash pulse width.
// - Feedback bit 22 enables half-rate output, halving tuning gain.
// - Chip-on low powers down and three-states the pump.
// - Serial input register stays active while powered down.
`ifndef SYNTH_PARAMS_SVH
`define SYNTH_PARAMS_SVH
`define WORD_W          24
`define SEL_CONTROL     2'h0
`define SEL_REFERENCE   2'h1
`define SEL_FEEDBACK    2'h2
`define SEL_TEST        2'h3
`define LOCK_SET_NS     15
`define LOCK_LOSE_NS    25
`define CLK_PERIOD_PS   5000
`define LOCK_SET_CYC    ((`LOCK_SET_NS * 1000) / `CLK_PERIOD_PS)
`define LOCK_LOSE_CYC   ((`LOCK_LOSE_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define LOCK_CNT_LO     3'h3
`define LOCK_CNT_HI     3'h5
`define BAND_CYCLES     3'h5
`define CTRL_RESET      24'h000000
`define REF_RESET       24'h000000
`define FB_RESET        24'h000000
`endif

// file: common/synth_pkg.sv
package synth_pkg;
   typedef struct packed {
      logic [1:0] prescaler_ratio;
      logic [1:0] powerdown_ctl;
      logic [2:0] pump_current_b;
      logic [2:0] pump_current_a;
      logic [1:0] drive_level;
      logic       mute_until_locked;
      logic       pump_gain_select;
      logic       pump_tristate;
      logic       detector_polarity;
      logic [2:0] output_select;
      logic       counter_clear;
      logic [1:0] core_current;
      logic [1:0] latch_select;
   } control_s;
   typedef struct packed {
      logic [1:0]  reserved;
      logic [1:0]  band_clock_div;
      logic        test_mode;
      logic        lock_precision_select;
      logic [1:0]  antibacklash_width;
      logic [13:0] ref_count;
      logic [1:0]  latch_select;
   } reference_s;
   typedef struct packed {
      logic        half_rate_route;
      logic        half_rate_enable;
      logic        pump_gain_select;
      logic [12:0] b_count;
      logic        reserved;
      logic [4:0]  a_count;
      logic [1:0]  latch_select;
   } feedback_s;
   typedef enum logic [1:0] {
      BAND_IDLE = 2'b00,
      BAND_WAIT = 2'b01,
      BAND_RUN  = 2'b10
   } band_state_e;
endpackage : synth_pkg

// file: logic/sync2.sv
`timescale 1ns/1ps
module sync2 (
   input  wire logic CLK,
   input  wire logic RSTN,
   input  wire logic d,
   output logic      q
);
   logic meta_reg;
   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         meta_reg <= 1'b0;
         q        <= 1'b0;
      end else begin
         meta_reg <= d;
         q        <= meta_reg;
      end
   end
endmodule : sync2

// file: logic/synth_serial_latch_lockdetect.sv
`timescale 1ns/1ps
`include "synth_params.svh"
module synth_serial_latch_lockdetect (
   // Clock and reset
   input  wire logic        CLK,
   input  wire logic        RSTN,
   // Three-wire serial link
   input  wire logic        SCLK,
   input  wire logic        SDATA,
   input  wire logic        LOAD_STROBE,
   // Chip-on pin
   input  wire logic        CHIP_ON,
   // Detector inputs from the dividers, plus scaled RF for the test output pin
   input  wire logic        REF_DIV_OUT,
   input  wire logic        FB_DIV_OUT,
   input  wire logic        RF_SCALED,
   // Outputs
   output logic             TEST_OUTPUT_PIN,
   output logic             LOCK_DETECT,
   output logic             BAND_SELECT_ACTIVE,
   output logic             TUNE_TO_REFERENCE,
   output logic             RF_SUPPLY_ON,
   output logic             PUMP_TRISTATE,
   output logic             POWERED_DOWN,
   output logic             HALF_RATE_ON,
   output logic [1:0]       CORE_CURRENT,
   output logic [1:0]       DRIVE_LEVEL,
   output logic [1:0]       ANTIBACKLASH_WIDTH,
   output logic [12:0]      B_COUNT,
   output logic [4:0]       A_COUNT,
   output logic [1:0]       PRESCALER_RATIO
);
   default clocking chk_clk @(posedge CLK);
   endclocking
   default disable iff (!RSTN);
   logic sclk_s, sdata_s, strobe_s, chip_on_s, ref_s, fb_s, rf_s;
   sync2 u_sclk   (.CLK(CLK), .RSTN(RSTN), .d(SCLK),        .q(sclk_s));
   sync2 u_sdata  (.CLK(CLK), .RSTN(RSTN), .d(SDATA),       .q(sdata_s));
   sync2 u_strobe (.CLK(CLK), .RSTN(RSTN), .d(LOAD_STROBE), .q(strobe_s));
   sync2 u_chipon (.CLK(CLK), .RSTN(RSTN), .d(CHIP_ON),     .q(chip_on_s));
   sync2 u_ref    (.CLK(CLK), .RSTN(RSTN), .d(REF_DIV_OUT), .q(ref_s));
   sync2 u_fb     (.CLK(CLK), .RSTN(RSTN), .d(FB_DIV_OUT),  .q(fb_s));
   sync2 u_rf     (.CLK(CLK), .RSTN(RSTN), .d(RF_SCALED),   .q(rf_s));

   logic                   sclk_d_reg, strobe_d_reg, ref_d_reg, fb_d_reg;
   logic [`WORD_W-1:0]     shift_reg;
   synth_pkg::control_s    ctrl_reg;
   synth_pkg::reference_s  refl_reg;
   synth_pkg::feedback_s   fbl_reg;
   logic [`WORD_W-1:0]     test_reg;
   logic                   sclk_rise, strobe_rise, ref_rise, fb_rise;
   logic                   fb_write;

   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         sclk_d_reg   <= 1'b0;
         strobe_d_reg <= 1'b0;
         ref_d_reg    <= 1'b0;
         fb_d_reg     <= 1'b0;
      end else begin
         sclk_d_reg   <= sclk_s;
         strobe_d_reg <= strobe_s;
         ref_d_reg    <= ref_s;
         fb_d_reg     <= fb_s;
      end
   end
   assign sclk_rise   = sclk_s & ~sclk_d_reg;
   assign strobe_rise = strobe_s & ~strobe_d_reg;
   assign ref_rise    = ref_s & ~ref_d_reg;
   assign fb_rise     = fb_s & ~fb_d_reg;

   // Shifts regardless of power state
   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         shift_reg <= '0;
      end else if (sclk_rise) begin
         shift_reg <= {shift_reg[`WORD_W-2:0], sdata_s};
      end
   end

   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         ctrl_reg <= `CTRL_RESET;
         refl_reg <= `REF_RESET;
         fbl_reg  <= `FB_RESET;
         test_reg <= '0;
      end else if (strobe_rise) begin
         unique case (shift_reg[1:0])
            `SEL_CONTROL:   ctrl_reg <= shift_reg;
            `SEL_REFERENCE: refl_reg <= shift_reg;
            `SEL_FEEDBACK:  fbl_reg  <= shift_reg;
            `SEL_TEST:      test_reg <= shift_reg;
         endcase
      end
   end
   assign fb_write = strobe_rise && (shift_reg[1:0] == `SEL_FEEDBACK);

   // Power-down: pin low or software power-down bit
   logic pd_now;
   assign pd_now = ~chip_on_s | ctrl_reg.powerdown_ctl[0];

   // Phase error timer: cycles between the two divider edges
   logic [7:0] err_cnt_reg;
   logic       err_open_reg;
   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         err_open_reg <= 1'b0;
         err_cnt_reg  <= 8'h00;
      end else if (ref_rise ^ fb_rise) begin
         err_open_reg <= ~err_open_reg;
         err_cnt_reg  <= 8'h00;
      end else if (err_open_reg && err_cnt_reg != 8'hFF) begin
         err_cnt_reg <= err_cnt_reg + 8'h01;
      end
   end

   // A detector cycle ends when the error window closes or both edges meet;
   // judging at the reference edge alone would miss a lagging feedback edge
   logic       pd_cycle, err_small, err_big, both_rise;
   logic [2:0] good_cnt_reg;
   logic [2:0] need;
   assign both_rise = ref_rise & fb_rise;
   assign pd_cycle  = both_rise | ((ref_rise ^ fb_rise) & err_open_reg);
   // Window count is one less than the edge spacing in clocks
   assign err_small = both_rise |
                      (err_cnt_reg < 8'(`LOCK_SET_CYC - 1));
   assign err_big   = ~both_rise &
                      (err_cnt_reg >= 8'(`LOCK_LOSE_CYC));
   assign need = refl_reg.lock_precision_select ? `LOCK_CNT_HI
                                                : `LOCK_CNT_LO;

   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         good_cnt_reg <= 3'h0;
         LOCK_DETECT  <= 1'b0;
      end else if (pd_now) begin
         good_cnt_reg <= 3'h0;
         LOCK_DETECT  <= 1'b0;
      end else if (pd_cycle) begin
         if (err_small) begin
            if (good_cnt_reg != 3'h7) good_cnt_reg <= good_cnt_reg + 3'h1;
            if (good_cnt_reg + 3'h1 >= need) LOCK_DETECT <= 1'b1;
         end else begin
            good_cnt_reg <= 3'h0;
         end
         if (LOCK_DETECT && err_big) LOCK_DETECT <= 1'b0;
      end
   end

   // Band clock prescale from reference edges
   logic [2:0] bdiv_reg;
   logic       band_tick;
   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         bdiv_reg <= 3'h0;
      end else if (ref_rise) begin
         bdiv_reg <= bdiv_reg + 3'h1;
      end
   end
   always_comb begin
      unique case (refl_reg.band_clock_div)
         2'h0: band_tick = ref_rise;
         2'h1: band_tick = ref_rise & bdiv_reg[0];
         2'h2: band_tick = ref_rise & (&bdiv_reg[1:0]);
         2'h3: band_tick = ref_rise & (&bdiv_reg);
      endcase
   end

   synth_pkg::band_state_e band_st_reg;
   logic [2:0]             band_cnt_reg;
   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         band_st_reg  <= synth_pkg::BAND_WAIT;
         band_cnt_reg <= 3'h0;
      end else if (fb_write) begin
         band_st_reg  <= synth_pkg::BAND_WAIT;
         band_cnt_reg <= 3'h0;
      end else begin
         unique case (band_st_reg)
            synth_pkg::BAND_IDLE: band_cnt_reg <= 3'h0;
            synth_pkg::BAND_WAIT:
               if (band_tick) band_st_reg <= synth_pkg::BAND_RUN;
            synth_pkg::BAND_RUN:
               if (band_tick) begin
                  if (band_cnt_reg == `BAND_CYCLES - 3'h1) begin
                     band_st_reg  <= synth_pkg::BAND_IDLE;
                     band_cnt_reg <= 3'h0;
                  end else begin
                     band_cnt_reg <= band_cnt_reg + 3'h1;
                  end
               end
            default: band_st_reg <= synth_pkg::BAND_IDLE;
         endcase
      end
   end

   // Registered outputs
   logic mux_val;
   always_comb begin
      unique case (ctrl_reg.output_select)
         3'h1:    mux_val = LOCK_DETECT;
         3'h2:    mux_val = ref_s;
         3'h4:    mux_val = rf_s;
         3'h5:    mux_val = ~LOCK_DETECT;
         3'h6:    mux_val = 1'b1;
         default: mux_val = 1'b0;
      endcase
   end

   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         TEST_OUTPUT_PIN    <= 1'b0;
         BAND_SELECT_ACTIVE <= 1'b0;
         TUNE_TO_REFERENCE  <= 1'b0;
         RF_SUPPLY_ON       <= 1'b0;
         PUMP_TRISTATE      <= 1'b1;
         POWERED_DOWN       <= 1'b1;
         HALF_RATE_ON       <= 1'b0;
         CORE_CURRENT       <= 2'h0;
         DRIVE_LEVEL        <= 2'h0;
         ANTIBACKLASH_WIDTH <= 2'h0;
         B_COUNT            <= 13'h0000;
         A_COUNT            <= 5'h00;
         PRESCALER_RATIO    <= 2'h0;
      end else begin
         TEST_OUTPUT_PIN    <= mux_val;
         BAND_SELECT_ACTIVE <= band_st_reg == synth_pkg::BAND_RUN;
         TUNE_TO_REFERENCE  <= band_st_reg == synth_pkg::BAND_RUN;
         RF_SUPPLY_ON       <= ~pd_now & (~ctrl_reg.mute_until_locked |
                                          LOCK_DETECT);
         PUMP_TRISTATE      <= pd_now | ctrl_reg.pump_tristate;
         POWERED_DOWN       <= pd_now;
         HALF_RATE_ON       <= fbl_reg.half_rate_enable;
         CORE_CURRENT       <= ctrl_reg.core_current;
         DRIVE_LEVEL        <= ctrl_reg.drive_level;
         ANTIBACKLASH_WIDTH <= refl_reg.antibacklash_width;
         B_COUNT            <= fbl_reg.b_count;
         A_COUNT            <= fbl_reg.a_count;
         PRESCALER_RATIO    <= ctrl_reg.prescaler_ratio;
      end
   end

   // Checks on the shift register, latches, detector, band selection and outputs
   a_lock_needs_cycle: assert property (
      $rose(LOCK_DETECT) |-> $past(pd_cycle) && $past(err_small))
      else $error("lock set without a good cycle");
   a_lock_count_met: assert property (
      $rose(LOCK_DETECT) |->
         $past(good_cnt_reg) + 3'h1 >= $past(need))
      else $error("lock set before enough cycles");
   a_lock_drop_cause: assert property (
      $fell(LOCK_DETECT) |-> $past(pd_now) || $past(err_big))
      else $error("lock dropped without large error");
   a_latch_hold_quiet: assert property (
      !strobe_rise |=> $stable(ctrl_reg) && $stable(fbl_reg))
      else $error("latch changed without strobe");
   a_shift_msb_first: assert property (
      sclk_rise |=> shift_reg[0] == $past(sdata_s)
                    && shift_reg[23:1] == $past(shift_reg[22:0]))
      else $error("shift order wrong");
   a_ctrl_load_sel: assert property (
      strobe_rise && shift_reg[1:0] == `SEL_CONTROL
      |=> ctrl_reg == $past(shift_reg))
      else $error("control latch not loaded");
   a_ref_load_sel: assert property (
      strobe_rise && shift_reg[1:0] == `SEL_REFERENCE
      |=> refl_reg == $past(shift_reg))
      else $error("reference latch not loaded");
   a_fb_load_sel: assert property (
      strobe_rise && shift_reg[1:0] == `SEL_FEEDBACK
      |=> fbl_reg == $past(shift_reg))
      else $error("feedback latch not loaded");
   a_band_restart: assert property (
      fb_write |=> band_st_reg == synth_pkg::BAND_WAIT)
      else $error("band select not restarted");
   a_band_run_hold: assert property (
      band_st_reg == synth_pkg::BAND_RUN && !band_tick && !fb_write
      |=> band_st_reg == synth_pkg::BAND_RUN)
      else $error("band select ended between ticks");
   a_mux_lock_out: assert property (
      ctrl_reg.output_select == 3'h1
      |=> TEST_OUTPUT_PIN == $past(LOCK_DETECT))
      else $error("test pin does not show lock");
   a_level_follow: assert property (
      1'b1 |=> DRIVE_LEVEL == $past(ctrl_reg.drive_level)
               && CORE_CURRENT == $past(ctrl_reg.core_current))
      else $error("level fields not on outputs");
   a_half_rate_out: assert property (
      1'b1 |=> HALF_RATE_ON == $past(fbl_reg.half_rate_enable))
      else $error("half rate not on output");
   a_mute_until_lock: assert property (
      RF_SUPPLY_ON && $past(ctrl_reg.mute_until_locked)
      |-> $past(LOCK_DETECT))
      else $error("output on before lock");
   a_pd_tristate: assert property (
      pd_now |=> PUMP_TRISTATE && POWERED_DOWN)
      else $error("pump not three-stated");
   a_pd_quiet_out: assert property (
      pd_now |=> !LOCK_DETECT && !RF_SUPPLY_ON)
      else $error("lock or output left on in power-down");
   a_shift_while_pd: assert property (
      pd_now && sclk_rise |=> shift_reg[0] == $past(sdata_s))
      else $error("shift stopped in power-down");
   // Main scenarios
   c_lock: cover property ($rose(LOCK_DETECT));
   c_precise_lock: cover property (
      $rose(LOCK_DETECT) && refl_reg.lock_precision_select);
   c_unlock: cover property ($fell(LOCK_DETECT));
   c_fb_write: cover property (fb_write);
   c_band_done: cover property ($fell(BAND_SELECT_ACTIVE));
endmodule : synth_serial_latch_lockdetect

// file: bench/serial_host_model.sv
`timescale 1ns/1ps
module serial_host_model (
   // System clock
   input  wire logic CLK,
   // Three-wire serial link
   output logic      SCLK,
   output logic      SDATA,
   output logic      LOAD_STROBE
);
   initial begin
      SCLK = 1'b0;
      SDATA = 1'b0;
      LOAD_STROBE = 1'b0;
   end

   task automatic hold(input int n);
      repeat (n) @(negedge CLK);
   endtask : hold

   // Each phase spans several system clocks so the synchroniser sees it
   task automatic send(input logic [23:0] w, input logic strobe);
      if (w[1:0] == 2'h3) begin
         return;
      end
      for (int i = 23; i >= 0; i--) begin
         SDATA = w[i];
         hold(2);
         SCLK = 1'b1;
         hold(4);
         SCLK = 1'b0;
         hold(2);
      end
      // Released data line must not show the last bit
      SDATA = ~SDATA;
      hold(2);
      if (strobe) begin
         LOAD_STROBE = 1'b1;
         hold(4);
         LOAD_STROBE = 1'b0;
         hold(8);
      end
   endtask : send
endmodule : serial_host_model

// file: bench/tb_synth_serial_latch_lockdetect.sv
`timescale 1ns/1ps
module tb_synth_serial_latch_lockdetect;
   logic        clk;
   logic        rstn;
   logic        chip_on;
   logic        ref_div;
   logic        fb_div;
   logic        sclk;
   logic        sdata;
   logic        load_strobe;
   logic        rf_scaled;
   logic        test_pin;
   logic        lock;
   logic        band_on;
   logic        tune_ref;
   logic        rf_on;
   logic        pump_ts;
   logic        pdown;
   logic        half_rate;
   logic [1:0]  core_cur;
   logic [1:0]  drive;
   logic [1:0]  abw;
   logic [12:0] b_cnt;
   logic [4:0]  a_cnt;
   logic [1:0]  presc;
   int          n_fail;
   int          tests_run;
   int          band_ticks;

   synth_serial_latch_lockdetect u_synth_serial_latch_lockdetect (
      .CLK(clk), .RSTN(rstn), .SCLK(sclk), .SDATA(sdata),
      .LOAD_STROBE(load_strobe), .CHIP_ON(chip_on),
      .REF_DIV_OUT(ref_div), .FB_DIV_OUT(fb_div), .RF_SCALED(rf_scaled),
      .TEST_OUTPUT_PIN(test_pin), .LOCK_DETECT(lock),
      .BAND_SELECT_ACTIVE(band_on), .TUNE_TO_REFERENCE(tune_ref),
      .RF_SUPPLY_ON(rf_on), .PUMP_TRISTATE(pump_ts), .POWERED_DOWN(pdown),
      .HALF_RATE_ON(half_rate), .CORE_CURRENT(core_cur),
      .DRIVE_LEVEL(drive), .ANTIBACKLASH_WIDTH(abw), .B_COUNT(b_cnt),
      .A_COUNT(a_cnt), .PRESCALER_RATIO(presc));

   serial_host_model u_serial_host_model (
      .CLK(clk), .SCLK(sclk), .SDATA(sdata), .LOAD_STROBE(load_strobe));

   always #2.5 clk = ~clk;

   // Detector cycles seen while band selection holds the tuning node
   always @(posedge ref_div) begin
      if (band_on === 1'b1 && tune_ref === 1'b1) begin
         band_ticks++;
      end
   end

   task automatic cmp_bit(input string what, input logic exp, input logic got);
      tests_run++;
      if (got !== exp) begin
         n_fail++;
         $display("[ERR] %s expected %b seen %b", what, exp, got);
      end
   endtask : cmp_bit

   task automatic cmp_val(input string what, input logic [12:0] exp,
                          input logic [12:0] got);
      tests_run++;
      if (got !== exp) begin
         n_fail++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask : cmp_val

   task automatic wr(input logic [23:0] w);
      u_serial_host_model.send(w, 1'b1);
   endtask : wr

   // Feedback edge trails the reference edge by lag system clocks
   task automatic ref_cycle(input int lag);
      @(negedge clk);
      ref_div = 1'b1;
      repeat (lag) @(negedge clk);
      fb_div = 1'b1;
      repeat (4) @(negedge clk);
      ref_div = 1'b0;
      fb_div = 1'b0;
      repeat (16) @(negedge clk);
   endtask : ref_cycle

   task automatic t_reset;
      repeat (12) @(negedge clk);
      cmp_bit("rst_pdown", 1'b1, pdown);
      cmp_bit("rst_pump", 1'b1, pump_ts);
      cmp_bit("rst_lock", 1'b0, lock);
      rstn = 1'b1;
      repeat (2) ref_cycle(0);
      cmp_bit("band_pwrup", 1'b1, band_on);
      $display("t_reset done");
   endtask : t_reset

   task automatic t_latches;
      wr(24'h020015);
      wr(24'h40282C);
      wr(24'h412356);
      cmp_val("abw", 13'h2, 13'(abw));
      cmp_val("presc", 13'h1, 13'(presc));
      cmp_val("drive", 13'h2, 13'(drive));
      cmp_val("core", 13'h3, 13'(core_cur));
      cmp_val("b_count", 13'h0123, b_cnt);
      cmp_val("a_count", 13'h15, 13'(a_cnt));
      cmp_bit("half_rate", 1'b1, half_rate);
      cmp_bit("pump_ts", 1'b0, pump_ts);
      u_serial_host_model.send(24'h000000, 1'b0);
      cmp_val("drive_hold", 13'h2, 13'(drive));
      cmp_val("core_hold", 13'h3, 13'(core_cur));
      $display("t_latches done");
   endtask : t_latches

   task automatic t_band(input logic [1:0] div, input int exp);
      wr(24'h020015 | {2'h0, div, 20'h0});
      wr(24'h412356);
      band_ticks = 0;
      // Room for the wait of up to one band tick plus the run itself
      repeat (exp + 10) ref_cycle(0);
      cmp_val("band_ticks", 13'(exp), 13'(band_ticks));
      cmp_bit("band_end", 1'b0, band_on);
      cmp_bit("tune_end", 1'b0, tune_ref);
      $display("t_band done");
   endtask : t_band

   task automatic t_lock(input logic prec, input int need);
      wr(24'h020015 | {5'h0, prec, 18'h0});
      ref_cycle(8);
      for (int i = 1; i <= need; i++) begin
         cmp_bit("rf_muted", 1'b0, rf_on);
         ref_cycle(0);
         cmp_bit("lock", i == need, lock);
      end
      cmp_bit("mux_lock", 1'b1, test_pin);
      cmp_bit("rf_on", 1'b1, rf_on);
      ref_cycle(4);
      cmp_bit("lock_hold", 1'b1, lock);
      ref_cycle(8);
      cmp_bit("lock_drop", 1'b0, lock);
      $display("t_lock done");
   endtask : t_lock

   task automatic t_mux;
      wr(24'h4028CC);
      cmp_bit("mux_one", 1'b1, test_pin);
      wr(24'h40280C);
      cmp_bit("mux_zero", 1'b0, test_pin);
      wr(24'h4028AC);
      cmp_bit("mux_nlock", 1'b1, test_pin);
      rf_scaled = 1'b1;
      wr(24'h40288C);
      cmp_bit("mux_rf_hi", 1'b1, test_pin);
      rf_scaled = 1'b0;
      repeat (4) @(negedge clk);
      cmp_bit("mux_rf_lo", 1'b0, test_pin);
      $display("t_mux done");
   endtask : t_mux

   task automatic t_power;
      repeat (3) ref_cycle(0);
      cmp_bit("relock", 1'b1, lock);
      chip_on = 1'b0;
      repeat (4) @(negedge clk);
      cmp_bit("pdown", 1'b1, pdown);
      cmp_bit("pump_off", 1'b1, pump_ts);
      cmp_bit("lock_off", 1'b0, lock);
      wr(24'h40182C);
      cmp_val("drive_pd", 13'h1, 13'(drive));
      chip_on = 1'b1;
      repeat (4) @(negedge clk);
      cmp_bit("pup", 1'b0, pdown);
      $display("t_power done");
   endtask : t_power

   task automatic finish_test;
      $display("checks %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : finish_test

   initial begin
      clk = 1'b0;
      rstn = 1'b0;
      chip_on = 1'b1;
      ref_div = 1'b0;
      fb_div = 1'b0;
      rf_scaled = 1'b0;
      n_fail = 0;
      tests_run = 0;
      band_ticks = 0;
      t_reset;
      t_latches;
      t_band(2'h0, 5);
      t_band(2'h1, 10);
      t_band(2'h2, 20);
      t_band(2'h3, 40);
      t_lock(1'b1, 5);
      t_lock(1'b0, 3);
      t_mux;
      t_power;
      finish_test;
   end

   // Whole run needs about 7000 clocks
   initial begin
      #200000;
      n_fail++;
      finish_test;
   end
endmodule : tb_synth_serial_latch_lockdetect
